// ===== cpu_status_pkg.sv
/*
  Constants for the CPU status word and its save registers: system register
  numbers, field positions, widths and clamp values.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package cpu_status_pkg;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned SREG_W      = 5;
  localparam int unsigned PSW_W       = 8;
  localparam int unsigned PC_W        = 26;
  // system register numbers
  localparam logic [4:0] SREG_PSW     = 5'h05;
  localparam logic [4:0] SREG_TC_PC   = 5'h10;
  localparam logic [4:0] SREG_TC_PSW  = 5'h11;
  localparam logic [4:0] SREG_TR_PC   = 5'h12;
  localparam logic [4:0] SREG_TR_PSW  = 5'h13;
  localparam logic [4:0] SREG_TC_BASE = 5'h14;
  // status word and pc bit positions
  localparam int unsigned BIT_ZERO    = 0;
  localparam int unsigned BIT_NEG     = 1;
  localparam int unsigned BIT_OVF     = 2;
  localparam int unsigned BIT_CARRY   = 3;
  localparam int unsigned BIT_CLAMP   = 4;
  localparam int unsigned BIT_IRQBLK  = 5;
  localparam int unsigned BIT_FAULT   = 6;
  localparam int unsigned BIT_NMI     = 7;
  localparam int unsigned BIT_PC_LSB  = 0;
  // reset values and clamp results
  localparam logic [7:0]  PSW_RESET   = 8'h00;
  localparam logic [25:0] PC_RESET    = 26'h0000000;
  localparam logic [31:0] SAT_POS_MAX = 32'h7FFFFFFF;
  localparam logic [31:0] SAT_NEG_MAX = 32'h80000000;
  localparam logic [31:0] ZERO_WORD   = 32'h00000000;
endpackage : cpu_status_pkg
`default_nettype wire

// ===== cpu_status_and_trap_save_regs.sv
/*
  CPU status word, table-call and trap save registers, table-call base.
  Assumes a core that issues one-cycle pulses for flag updates, system
  register loads, table calls, debug traps, exceptions and returns.
  All inputs come from logic on clk_sys, so none is synchronised here.
  The core is expected to set the irq-block bit itself after an irq ack,
  since acks repeat every cycle while a request stays high and unblocked.
*/
`timescale 1ns/1ns
`default_nettype none
module cpu_status_and_trap_save_regs
  import cpu_status_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // system register load / store
  input  wire logic               sysregLoad,
  input  wire logic [SREG_W-1:0]  sysregLoadSel,
  input  wire logic [DATA_W-1:0]  sysregLoadData,
  input  wire logic [SREG_W-1:0]  sysregReadSel,
  output logic      [DATA_W-1:0]  sysregReadData,
  output logic                    sysregAccessFault,
  // arithmetic flag update
  input  wire logic               flagUpdate,
  input  wire logic               flagSaturating,
  input  wire logic [DATA_W-1:0]  flagResult,
  input  wire logic               flagCarry,
  input  wire logic               flagOverflow,
  output logic      [DATA_W-1:0]  satResult,
  // program flow
  input  wire logic [PC_W-1:0]    nextPc,
  input  wire logic               tableCallInsn,
  input  wire logic               debugTrapInsn,
  input  wire logic               debugReturnInsn,
  input  wire logic               exceptionEvent,
  output logic                    pcLoad,
  output logic      [PC_W-1:0]    pcLoadValue,
  // interrupts
  input  wire logic               irqRequest,
  input  wire logic               nmiRequest,
  output logic                    irqAck,
  output logic                    nmiAck,
  // status view
  output logic      [PSW_W-1:0]   programStatusWord,
  output logic      [DATA_W-1:0]  tableCallBase
);

  // ***************************************************************
  // state
  // ***************************************************************
  logic [PSW_W-1:0] psw_reg;
  logic [PSW_W-1:0] psw_next;
  logic [PC_W-1:0]  tcPc_reg;
  logic [PSW_W-1:0] tcPsw_reg;
  logic [PC_W-1:0]  trPc_reg;
  logic [PSW_W-1:0] trPsw_reg;
  logic [PC_W-1:0]  tcBase_reg;
  logic             trapWindow_reg;
  logic             irqAck_reg;
  logic             nmiAck_reg;
  logic             pcLoad_reg;
  logic [PC_W-1:0]  pcLoadValue_reg;
  logic [DATA_W-1:0] readData_reg;
  logic             accessFault_reg;
  logic [DATA_W-1:0] satResult_reg;

  // ***************************************************************
  // decode
  // ***************************************************************
  logic pswWrite;
  logic trapSel;
  logic trapLoadOk;
  logic nmiTake;
  logic irqTake;
  logic resNeg;
  logic resZero;
  logic satPos;
  logic satNeg;
  logic tcPcWrite;
  logic tcPswWrite;
  logic trPcWrite;
  logic trPswWrite;
  logic tcBaseWrite;
  logic trapAccessBad;
  logic [DATA_W-1:0] readData_next;
  logic              accessFault_next;
  logic [DATA_W-1:0] satResult_next;

  assign pswWrite   = sysregLoad && (sysregLoadSel == SREG_PSW);
  assign trapSel    = (sysregLoadSel == SREG_TR_PC) || (sysregLoadSel == SREG_TR_PSW);
  assign trapLoadOk = sysregLoad && trapSel && trapWindow_reg;

  // ***************************************************************
  // per-register write strobes
  // ***************************************************************
  assign tcPcWrite     = sysregLoad && (sysregLoadSel == SREG_TC_PC);
  assign tcPswWrite    = sysregLoad && (sysregLoadSel == SREG_TC_PSW);
  assign trPcWrite     = trapLoadOk && (sysregLoadSel == SREG_TR_PC);
  assign trPswWrite    = trapLoadOk && (sysregLoadSel == SREG_TR_PSW);
  assign tcBaseWrite   = sysregLoad && (sysregLoadSel == SREG_TC_BASE);
  // trap save load outside the window is dropped and flagged
  assign trapAccessBad = sysregLoad && trapSel && !trapWindow_reg;

  // ***************************************************************
  // interrupt acceptance
  // ***************************************************************
  // nmi refused while one is active; maskable also needs block bit clear
  assign nmiTake = nmiRequest && !psw_reg[BIT_NMI] && !pswWrite;
  assign irqTake = irqRequest && !nmiTake && !psw_reg[BIT_NMI]
                   && !psw_reg[BIT_IRQBLK] && !pswWrite;

  assign resNeg  = flagResult[DATA_W-1];
  assign resZero = (flagResult == ZERO_WORD);
  // overflow sign: positive overflow shows a negative raw result
  assign satPos  = flagSaturating && flagOverflow && resNeg;
  assign satNeg  = flagSaturating && flagOverflow && !resNeg;

  // ***************************************************************
  // status word next value
  // ***************************************************************
  always_comb
  begin
    psw_next = psw_reg;
    if (flagUpdate)
    begin
      psw_next[BIT_CARRY] = flagCarry;
      psw_next[BIT_OVF]   = flagOverflow;
      psw_next[BIT_NEG]   = resNeg;
      psw_next[BIT_ZERO]  = resZero;
      if (satPos)
      begin
        psw_next[BIT_NEG]   = 1'b0;
        psw_next[BIT_ZERO]  = 1'b0;
        psw_next[BIT_CLAMP] = 1'b1;
      end
      else if (satNeg)
      begin
        psw_next[BIT_NEG]   = 1'b1;
        psw_next[BIT_ZERO]  = 1'b0;
        psw_next[BIT_CLAMP] = 1'b1;
      end
    end
    if (exceptionEvent || debugTrapInsn)
      psw_next[BIT_FAULT] = 1'b1;
    if (nmiTake)
      psw_next[BIT_NMI] = 1'b1;
    if (debugReturnInsn)
      psw_next = trPsw_reg;
    if (pswWrite)
      psw_next = sysregLoadData[PSW_W-1:0];
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      psw_reg <= PSW_RESET;
    else
      psw_reg <= psw_next;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tcPc_reg  <= PC_RESET;
      tcPsw_reg <= PSW_RESET;
    end
    else if (tableCallInsn)
    begin
      tcPc_reg  <= nextPc;
      tcPsw_reg <= psw_reg;
    end
    else if (tcPcWrite)
      tcPc_reg <= sysregLoadData[PC_W-1:0];
    else if (tcPswWrite)
      tcPsw_reg <= sysregLoadData[PSW_W-1:0];
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trPc_reg  <= PC_RESET;
      trPsw_reg <= PSW_RESET;
    end
    else if (exceptionEvent || debugTrapInsn)
    begin
      trPc_reg  <= nextPc;
      trPsw_reg <= psw_reg;
    end
    else if (trPcWrite)
      trPc_reg <= sysregLoadData[PC_W-1:0];
    else if (trPswWrite)
      trPsw_reg <= sysregLoadData[PSW_W-1:0];
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      trapWindow_reg <= 1'b0;
    else if (exceptionEvent || debugTrapInsn)
      trapWindow_reg <= 1'b1;
    else if (debugReturnInsn)
      trapWindow_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      tcBase_reg <= PC_RESET;
    else if (tcBaseWrite)
    begin
      tcBase_reg <= sysregLoadData[PC_W-1:0];
      tcBase_reg[BIT_PC_LSB] <= 1'b0;
    end
  end

  // ***************************************************************
  // flow and interrupt outputs
  // ***************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      irqAck_reg <= 1'b0;
    else
      irqAck_reg <= irqTake;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      nmiAck_reg <= 1'b0;
    else
      nmiAck_reg <= nmiTake;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pcLoad_reg      <= 1'b0;
      pcLoadValue_reg <= PC_RESET;
    end
    else
    begin
      pcLoad_reg <= debugReturnInsn;
      if (debugReturnInsn)
        pcLoadValue_reg <= trPc_reg;
    end
  end

  // ***************************************************************
  // clamp result
  // ***************************************************************
  always_comb
  begin
    satResult_next = satResult_reg;
    if (flagUpdate)
    begin
      if (satPos)
        satResult_next = SAT_POS_MAX;
      else if (satNeg)
        satResult_next = SAT_NEG_MAX;
      else
        satResult_next = flagResult;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      satResult_reg <= ZERO_WORD;
    else
      satResult_reg <= satResult_next;
  end

  // ***************************************************************
  // register read port
  // ***************************************************************
  // unused upper bits stay zero because every read starts from zero
  always_comb
  begin
    readData_next    = ZERO_WORD;
    accessFault_next = trapAccessBad;
    unique case (sysregReadSel)
      SREG_PSW:     readData_next[PSW_W-1:0] = psw_reg;
      SREG_TC_PC:   readData_next[PC_W-1:0]  = tcPc_reg;
      SREG_TC_PSW:  readData_next[PSW_W-1:0] = tcPsw_reg;
      SREG_TR_PC:
      begin
        if (trapWindow_reg)
          readData_next[PC_W-1:0] = trPc_reg;
        else
          accessFault_next = 1'b1;
      end
      SREG_TR_PSW:
      begin
        if (trapWindow_reg)
          readData_next[PSW_W-1:0] = trPsw_reg;
        else
          accessFault_next = 1'b1;
      end
      SREG_TC_BASE: readData_next[PC_W-1:0] = tcBase_reg;
      default:      readData_next = ZERO_WORD;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      readData_reg    <= ZERO_WORD;
      accessFault_reg <= 1'b0;
    end
    else
    begin
      readData_reg    <= readData_next;
      accessFault_reg <= accessFault_next;
    end
  end

  // ***************************************************************
  // output drive, all straight from flip-flops
  // ***************************************************************

  assign sysregReadData    = readData_reg;
  assign sysregAccessFault = accessFault_reg;
  assign satResult         = satResult_reg;
  assign pcLoad            = pcLoad_reg;
  assign pcLoadValue       = pcLoadValue_reg;
  assign irqAck            = irqAck_reg;
  assign nmiAck            = nmiAck_reg;
  assign programStatusWord = psw_reg;
  assign tableCallBase     = {{(DATA_W-PC_W){1'b0}}, tcBase_reg};

endmodule // cpu_status_and_trap_save_regs
`default_nettype wire

// ===== cpu_status_checker.sv
/*
  Assertions on the status word block, bound to every instance.
  Assumes only the ports of the block and its package.
*/
`timescale 1ns/1ns
`default_nettype none
module cpu_status_checker
  import cpu_status_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              rst_n,
  input wire logic              sysregLoad,
  input wire logic [SREG_W-1:0] sysregLoadSel,
  input wire logic [DATA_W-1:0] sysregLoadData,
  input wire logic [SREG_W-1:0] sysregReadSel,
  input wire logic [DATA_W-1:0] sysregReadData,
  input wire logic              flagUpdate,
  input wire logic              flagSaturating,
  input wire logic [DATA_W-1:0] flagResult,
  input wire logic              flagCarry,
  input wire logic              flagOverflow,
  input wire logic [DATA_W-1:0] satResult,
  input wire logic              debugReturnInsn,
  input wire logic              exceptionEvent,
  input wire logic              pcLoad,
  input wire logic              irqAck,
  input wire logic              nmiAck,
  input wire logic [7:0]        programStatusWord,
  input wire logic [DATA_W-1:0] tableCallBase
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic stLoad;
  logic quiet;
  assign stLoad = sysregLoad && sysregLoadSel == 5'h05;
  assign quiet  = !stLoad && !debugReturnInsn;
  a_load_effect:
    assert property (stLoad |=> programStatusWord == $past(sysregLoadData[7:0]))
    else $error("status load not applied");
  a_load_holds_irq:
    assert property (stLoad |=> !irqAck && !nmiAck) else $error("ack during status load");
  a_read_upper:
    assert property (sysregReadSel == 5'h05 |=> sysregReadData[31:8] == 24'h000000)
    else $error("status upper bits not zero");
  a_nmi_flag:
    assert property (nmiAck && !$past(debugReturnInsn) |-> programStatusWord[7])
    else $error("nmi flag not set");
  a_irq_blocked:
    assert property (programStatusWord[5] || programStatusWord[7] |=> !irqAck)
    else $error("irq taken while blocked");
  a_fault_flag:
    assert property (exceptionEvent && quiet |=> programStatusWord[6])
    else $error("fault flag not set");
  a_clamp_sticky:
    assert property (programStatusWord[4] && quiet |=> programStatusWord[4])
    else $error("clamp flag cleared");
  a_flags_plain:
    assert property (flagUpdate && !flagSaturating && quiet |=> programStatusWord[3:0] ==
      {$past(flagCarry), $past(flagOverflow), $past(flagResult[31]), $past(flagResult) == 0})
    else $error("arithmetic flags wrong");
  a_clamp_pos:
    assert property (flagUpdate && flagSaturating && flagOverflow && flagResult[31] && quiet
      |=> satResult == 32'h7FFFFFFF && programStatusWord[4:1] ==? 4'b1x10)
    else $error("positive clamp wrong");
  a_clamp_neg:
    assert property (flagUpdate && flagSaturating && flagOverflow && !flagResult[31] && quiet
      |=> satResult == 32'h80000000 && programStatusWord[4:1] ==? 4'b1x11)
    else $error("negative clamp wrong");
  a_return_pc:
    assert property (debugReturnInsn |=> pcLoad) else $error("no pc reload on return");
  a_base_zero:
    assert property (tableCallBase[0] == 1'b0 && tableCallBase[31:26] == 6'h00)
    else $error("table base fixed bits set");
endmodule // cpu_status_checker
bind cpu_status_and_trap_save_regs cpu_status_checker u_chk (.clk_sys, .rst_n, .sysregLoad,
  .sysregLoadSel, .sysregLoadData, .sysregReadSel, .sysregReadData, .flagUpdate,
  .flagSaturating, .flagResult, .flagCarry, .flagOverflow, .satResult, .debugReturnInsn,
  .exceptionEvent, .pcLoad, .irqAck, .nmiAck, .programStatusWord, .tableCallBase);
`default_nettype wire

// ===== cpu_status_and_trap_save_regs_test.sv
/*
  Self-checking bench for the status word block.
  Assumes the checker is attached by bind; inputs change at falling edges.
*/
`timescale 1ns/1ns
`default_nettype none
module cpu_status_and_trap_save_regs_test;
  logic        clk_sys, rst_n, sysregLoad, flagUpdate, flagSaturating, flagCarry, flagOverflow;
  logic        tableCallInsn, debugTrapInsn, debugReturnInsn, exceptionEvent, irqRequest;
  logic        nmiRequest, sysregAccessFault, pcLoad, irqAck, nmiAck;
  logic [4:0]  sysregLoadSel, sysregReadSel;
  logic [31:0] sysregLoadData, sysregReadData, flagResult, satResult, tableCallBase, v;
  logic [25:0] nextPc, pcLoadValue;
  logic [7:0]  programStatusWord, st;
  int          error_cnt, checked;
  cpu_status_and_trap_save_regs u_dut (.clk_sys, .rst_n, .sysregLoad, .sysregLoadSel,
    .sysregLoadData, .sysregReadSel, .sysregReadData, .sysregAccessFault, .flagUpdate,
    .flagSaturating, .flagResult, .flagCarry, .flagOverflow, .satResult, .nextPc,
    .tableCallInsn, .debugTrapInsn, .debugReturnInsn, .exceptionEvent, .pcLoad,
    .pcLoadValue, .irqRequest, .nmiRequest, .irqAck, .nmiAck, .programStatusWord,
    .tableCallBase);
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  function automatic logic [3:0] plainFlags(input logic [31:0] r, input logic c, input logic o);
    return {c, o, r[31], r == 32'h00000000};
  endfunction
  function automatic logic [31:0] clampVal(input logic [31:0] r);
    return r[31] ? 32'h7FFFFFFF : 32'h80000000;
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask
  task automatic step();
    @(negedge clk_sys);
  endtask
  task automatic ld(input logic [4:0] sel, input logic [31:0] d);
    sysregLoad = 1'b1;
    sysregLoadSel = sel;
    sysregLoadData = d;
    step();
    sysregLoad = 1'b0;
  endtask
  task automatic rd(input logic [4:0] sel, input logic [31:0] exp);
    sysregReadSel = sel;
    step();
    chk("sysregReadData", exp, sysregReadData);
  endtask
  task automatic fl(input logic s, input logic [31:0] r, input logic c, input logic o);
    flagUpdate = 1'b1;
    flagSaturating = s;
    flagResult = r;
    flagCarry = c;
    flagOverflow = o;
    step();
    flagUpdate = 1'b0;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #400000;
    error_cnt++;
    end_of_test();
  end
  initial
  begin
    {sysregLoad, flagUpdate, flagSaturating, flagCarry, flagOverflow, nmiRequest} = '0;
    {tableCallInsn, debugTrapInsn, debugReturnInsn, exceptionEvent, irqRequest} = '0;
    {sysregLoadSel, sysregReadSel, sysregLoadData, flagResult, nextPc} = '0;
    rst_n = 1'b0;
    error_cnt = 0;
    checked = 0;
    v = $urandom(32'h328CD8B8);
    repeat (4) step();
    rst_n = 1'b1;
    step();
    ld(5'h12, 32'h00001234);
    chk("sysregAccessFault", 1, sysregAccessFault);
    rd(5'h12, 32'h00000000);
    ld(5'h05, 32'hFFFFFFFF);
    rd(5'h05, 32'h000000FF);
    repeat (6)
    begin
      v = $urandom();
      ld(5'h05, v);
      chk("programStatusWord", v[7:0], programStatusWord);
      rd(5'h05, {24'h000000, v[7:0]});
    end
    ld(5'h05, 32'h00000000);
    st = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      v = (i == 0) ? 32'h00000000 : $urandom();
      fl(1'b0, v, v[3], v[9]);
      st[3:0] = plainFlags(v, v[3], v[9]);
      chk("programStatusWord", st, programStatusWord);
    end
    fl(1'b0, 32'h80000000, 1'b0, 1'b1);
    chk("programStatusWord", 8'h06, programStatusWord);
    fl(1'b1, 32'h80000000, 1'b0, 1'b1);
    chk("satResult", clampVal(32'h80000000), satResult);
    chk("clampBits", 8'h14, programStatusWord & 8'h16);
    fl(1'b1, 32'h7FFFFFFF, 1'b1, 1'b1);
    chk("satResult", clampVal(32'h7FFFFFFF), satResult);
    chk("clampBits", 8'h16, programStatusWord & 8'h16);
    v = $urandom() | 32'h80000000;
    fl(1'b1, v, 1'b0, 1'b0);
    chk("satResult", v, satResult);
    chk("clampBits", 8'h12, programStatusWord & 8'h16);
    fl(1'b0, 32'h00000001, 1'b0, 1'b0);
    chk("programStatusWord", 8'h10, programStatusWord);
    ld(5'h05, 32'h00000000);
    irqRequest = 1'b1;
    step();
    chk("irqAck", 1, irqAck);
    ld(5'h05, 32'h00000020);
    chk("irqAck", 0, irqAck);
    step();
    chk("irqAck", 0, irqAck);
    ld(5'h05, 32'h00000000);
    exceptionEvent = 1'b1;
    step();
    exceptionEvent = 1'b0;
    chk("programStatusWord", 8'h40, programStatusWord);
    step();
    chk("irqAck", 1, irqAck);
    nmiRequest = 1'b1;
    step();
    chk("nmiAck", 1, nmiAck);
    chk("irqAck", 0, irqAck);
    chk("programStatusWord", 8'hC0, programStatusWord);
    step();
    chk("nmiAck", 0, nmiAck);
    chk("irqAck", 0, irqAck);
    {nmiRequest, irqRequest} = 2'b00;
    nextPc = $urandom() & 26'h3FFFFFE;
    tableCallInsn = 1'b1;
    step();
    tableCallInsn = 1'b0;
    rd(5'h10, {6'h00, nextPc});
    rd(5'h11, 32'h000000C0);
    ld(5'h10, 32'hFFFFFFFF);
    rd(5'h10, 32'h03FFFFFF);
    ld(5'h11, 32'hFFFFFFFF);
    rd(5'h11, 32'h000000FF);
    ld(5'h14, 32'hFFFFFFFF);
    chk("tableCallBase", 32'h03FFFFFE, tableCallBase);
    ld(5'h05, 32'h00000000);
    nextPc = $urandom() & 26'h3FFFFFE;
    debugTrapInsn = 1'b1;
    step();
    debugTrapInsn = 1'b0;
    rd(5'h12, {6'h00, nextPc});
    rd(5'h13, 32'h00000000);
    ld(5'h12, 32'hFFFFFFFF);
    chk("sysregAccessFault", 0, sysregAccessFault);
    rd(5'h12, 32'h03FFFFFF);
    ld(5'h13, 32'hFFFFFF0B);
    rd(5'h13, 32'h0000000B);
    debugReturnInsn = 1'b1;
    step();
    debugReturnInsn = 1'b0;
    chk("pcLoad", 1, pcLoad);
    chk("pcLoadValue", 32'h03FFFFFF, pcLoadValue);
    chk("programStatusWord", 8'h0B, programStatusWord);
    ld(5'h12, 32'h00000000);
    chk("sysregAccessFault", 1, sysregAccessFault);
    end_of_test();
  end
endmodule // cpu_status_and_trap_save_regs_test
`default_nettype wire
